// ---- rtl/scf_fifo.sv ----
`timescale 1ns/100ps
module scf_fifo import scf_pkg::*; #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // Fill side
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire logic [WIDTH-1:0]           in_data,
  // Drain side
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [WIDTH-1:0]                out_data,
  // Fill level
  output logic [$clog2(DEPTH+1)-1:0]      level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    rd_reg;
  logic [$clog2(DEPTH+1)-1:0] cnt_reg;
  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;
  // A full queue still accepts a byte when one leaves in the same cycle
  assign in_ready  = (cnt_reg != DEPTH[$clog2(DEPTH+1)-1:0]) || out_ready;
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rd_reg];
  assign level     = cnt_reg;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

// ---- rtl/scf_pkg.sv ----
package scf_pkg;
  // Register offsets
  localparam logic [6:0] OFS_USER_CONTROL   = 7'h6A;
  localparam logic [6:0] OFS_POWER_ONE      = 7'h6B;
  localparam logic [6:0] OFS_POWER_TWO      = 7'h6C;
  localparam logic [6:0] OFS_COUNT_HIGH     = 7'h72;
  localparam logic [6:0] OFS_COUNT_LOW      = 7'h73;
  localparam logic [6:0] OFS_DATA_PORT      = 7'h74;
  localparam logic [6:0] OFS_IDENTITY       = 7'h75;
  // User control fields
  localparam int BIT_QUEUE_ENABLE           = 6;
  localparam int BIT_TWO_WIRE_TARGET_DIS    = 4;
  localparam int BIT_QUEUE_RESET            = 2;
  localparam int BIT_SIGNAL_PATH_CLEAR_ALL  = 0;
  // Power control one fields
  localparam int BIT_DEVICE_RESET           = 7;
  localparam int BIT_SLEEP                  = 6;
  localparam int BIT_ACCEL_CYCLE            = 5;
  localparam int BIT_RATE_STANDBY           = 4;
  localparam int BIT_THERMAL_SENSOR_OFF     = 3;
  // Power control two fields
  localparam int BIT_QUEUE_LOW_POWER_ENABLE = 7;
  // Writable masks (reserved bits read zero)
  localparam logic [7:0] MASK_USER_CONTROL  = 8'h50;
  localparam logic [7:0] MASK_POWER_ONE     = 8'h7F;
  localparam logic [7:0] MASK_POWER_TWO     = 8'hBF;
  // Reset values
  localparam logic [7:0] RST_USER_CONTROL   = 8'h00;
  localparam logic [7:0] RST_POWER_ONE      = 8'h40;
  localparam logic [7:0] RST_POWER_TWO      = 8'h00;
  // Empty queue read value
  localparam logic [7:0] EMPTY_READ_VALUE   = 8'hFF;
  // Arbitrary identity value
  localparam logic [7:0] PART_IDENTITY_CODE = 8'h5A;
  // Timing: one period of the 20 MHz internal clock
  localparam int OSC_PERIOD_NS              = 50;
  localparam int CLK_PERIOD_NS              = 8;
  localparam int QUEUE_RESET_CYCLES         = OSC_PERIOD_NS / CLK_PERIOD_NS;
  // Timing source decode
  typedef enum logic [1:0] {
    SCF_SRC_OSC  = 2'b00,
    SCF_SRC_AUTO = 2'b01,
    SCF_SRC_STOP = 2'b11
  } scf_src_e;
  function automatic scf_src_e scf_decode_src(input logic [2:0] code);
    if (code == 3'h0 || code == 3'h6) begin
      return SCF_SRC_OSC;
    end
    if (code == 3'h7) begin
      return SCF_SRC_STOP;
    end
    return SCF_SRC_AUTO;
  endfunction
endpackage

// ---- rtl/scf_regs.sv ----
`timescale 1ns/100ps
module scf_regs import scf_pkg::*; #(
  parameter int DEPTH    = 32,
  parameter int CNT_BITS = 13
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port from serial interface
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [6:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic [7:0]             reg_rdata,
  // Sensor byte stream, ascending register order
  input  wire logic              sensor_valid,
  input  wire logic [7:0]        sensor_data,
  input  wire logic              sensor_enabled,
  output logic                   sensor_ready,
  // Configuration from outside the block
  input  wire logic              queue_mode_keep,
  input  wire logic              pll_ready,
  // Control outputs
  output logic                   queue_enable,
  output logic                   two_wire_target_disable,
  output logic                   signal_path_clear_all,
  output logic                   sleep_mode,
  output logic                   accel_cycle_active,
  output logic                   cycle_take_sample,
  output logic                   rate_sense_off,
  output logic                   rate_drive_on,
  output logic                   thermal_sensor_off,
  output logic [1:0]             timing_source,
  output logic                   timing_gen_reset,
  output logic                   queue_low_power_enable,
  output logic [5:0]             axis_off,
  output logic                   queue_overflow_flag
);
  logic [7:0] user_reg;
  logic [7:0] pwr1_reg;
  logic [7:0] pwr2_reg;
  logic [4:0] qrst_cnt_reg;
  logic       spc_reg;
  logic [CNT_BITS-1:0] cnt_latch_reg;
  logic [7:0] rdata_reg;
  logic       ovf_reg;
  logic       qen_reg, twd_reg, slp_reg, cyc_reg, smp_reg, rso_reg, tso_reg, lpe_reg;
  logic [1:0] src_reg;
  logic       tgr_reg;
  logic [5:0] axis_reg;
  logic       pll_meta_reg;
  logic       pll_sync_reg;
  logic       rdo_reg;
  localparam int                 LVL_BITS   = $clog2(DEPTH + 1);
  localparam logic [LVL_BITS-1:0] FULL_LEVEL = LVL_BITS'(DEPTH);

  // Decodes
  wire wr_user  = reg_wr && reg_addr == OFS_USER_CONTROL;
  wire wr_pwr1  = reg_wr && reg_addr == OFS_POWER_ONE;
  wire wr_pwr2  = reg_wr && reg_addr == OFS_POWER_TWO;
  wire wr_data  = reg_wr && reg_addr == OFS_DATA_PORT;
  wire rd_data  = reg_rd && reg_addr == OFS_DATA_PORT;
  wire rd_cnth  = reg_rd && reg_addr == OFS_COUNT_HIGH;
  wire dev_rst  = wr_pwr1 && reg_wdata[BIT_DEVICE_RESET];
  wire soft_rst = rst || dev_rst;
  wire qrst_hit = wr_user && reg_wdata[BIT_QUEUE_RESET];
  wire q_clear  = soft_rst || qrst_hit || qrst_cnt_reg != '0;
  wire q_en     = user_reg[BIT_QUEUE_ENABLE];

  // Queue fill: host writes win over sensor bytes
  wire host_push   = wr_data && q_en;
  wire sens_push   = sensor_valid && sensor_enabled && !host_push;
  wire push_req    = host_push || sens_push;
  wire [7:0] push_d = host_push ? reg_wdata : sensor_data;
  wire q_full;
  wire q_out_valid;
  wire [7:0] q_out_data;
  wire [$clog2(DEPTH+1)-1:0] q_level;
  assign q_full = (q_level == FULL_LEVEL);
  wire ovf_evt    = push_req && q_full;
  wire drop_old   = ovf_evt && !queue_mode_keep;
  wire host_pop   = rd_data && q_en && q_out_valid;
  wire q_pop      = host_pop || drop_old;
  wire q_push     = push_req && (!q_full || drop_old);

  scf_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (q_clear),
    .in_valid  (q_push),
    .in_ready  (),
    .in_data   (push_d),
    .out_valid (q_out_valid),
    .out_ready (q_pop),
    .out_data  (q_out_data),
    .level     (q_level)
  );

  // Sensor source stalls when the host writes the data port with the queue enabled, or when full and keeping old data
  wire sens_ready = !host_push && (!q_full || !queue_mode_keep);

  // Read data selection
  wire [7:0] data_port_val = (q_en && q_out_valid) ? q_out_data : EMPTY_READ_VALUE;
  wire [CNT_BITS-1:0] live_cnt = CNT_BITS'(q_level);
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      OFS_USER_CONTROL: rd_mux = user_reg;
      OFS_POWER_ONE:    rd_mux = pwr1_reg;
      OFS_POWER_TWO:    rd_mux = pwr2_reg;
      OFS_COUNT_HIGH:   rd_mux = {3'h0, live_cnt[12:8]};
      OFS_COUNT_LOW:    rd_mux = cnt_latch_reg[7:0];
      OFS_DATA_PORT:    rd_mux = data_port_val;
      OFS_IDENTITY:     rd_mux = PART_IDENTITY_CODE;
      default:          rd_mux = 8'h00;
    endcase
  end

  // Power mode decode
  wire [2:0] src_code = pwr1_reg[2:0];
  scf_src_e  src_sel;
  assign src_sel = scf_decode_src(src_code);
  wire src_auto_pll = (src_sel == SCF_SRC_AUTO) && pll_sync_reg;
  wire cyc_on  = pwr1_reg[BIT_ACCEL_CYCLE] && !pwr1_reg[BIT_SLEEP]
               && !pwr1_reg[BIT_RATE_STANDBY];
  wire accel_all_off = &pwr2_reg[5:3];
  wire cyc_sample    = cyc_on && !accel_all_off;

  // Lock status comes from the PLL domain
  always_ff @(posedge clk) begin
    if (rst) begin
      pll_meta_reg <= 1'b0;
      pll_sync_reg <= 1'b0;
    end else begin
      pll_meta_reg <= pll_ready;
      pll_sync_reg <= pll_meta_reg;
    end
  end

  // Register file
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      user_reg <= RST_USER_CONTROL;
      pwr1_reg <= RST_POWER_ONE;
      pwr2_reg <= RST_POWER_TWO;
    end else begin
      if (wr_user) begin
        user_reg <= reg_wdata & MASK_USER_CONTROL;
      end
      if (wr_pwr1) begin
        pwr1_reg <= reg_wdata & MASK_POWER_ONE;
      end
      if (wr_pwr2) begin
        pwr2_reg <= reg_wdata & MASK_POWER_TWO;
      end
    end
  end

  // Self-clearing pulses
  always_ff @(posedge clk) begin
    if (soft_rst) begin
      qrst_cnt_reg <= '0;
      spc_reg      <= 1'b0;
    end else begin
      if (qrst_hit) begin
        qrst_cnt_reg <= 5'(QUEUE_RESET_CYCLES);
      end else if (qrst_cnt_reg != '0) begin
        qrst_cnt_reg <= qrst_cnt_reg - 1'b1;
      end
      spc_reg <= wr_user && reg_wdata[BIT_SIGNAL_PATH_CLEAR_ALL];
    end
  end

  // Count latch, overflow flag and read data
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_latch_reg <= '0;
      ovf_reg       <= 1'b0;
      rdata_reg     <= 8'h00;
    end else begin
      if (rd_cnth) begin
        cnt_latch_reg <= live_cnt;
      end
      ovf_reg   <= ovf_evt;
      rdata_reg <= reg_rd ? rd_mux : rdata_reg;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      qen_reg  <= 1'b0;
      twd_reg  <= 1'b0;
      slp_reg  <= 1'b1;
      cyc_reg  <= 1'b0;
      smp_reg  <= 1'b0;
      rso_reg  <= 1'b0;
      tso_reg  <= 1'b0;
      src_reg  <= SCF_SRC_OSC;
      tgr_reg  <= 1'b0;
      lpe_reg  <= 1'b0;
      axis_reg <= 6'h00;
      rdo_reg  <= 1'b1;
    end else begin
      rdo_reg  <= 1'b1;
      qen_reg  <= q_en;
      twd_reg  <= user_reg[BIT_TWO_WIRE_TARGET_DIS];
      slp_reg  <= pwr1_reg[BIT_SLEEP];
      cyc_reg  <= cyc_on;
      smp_reg  <= cyc_sample;
      rso_reg  <= pwr1_reg[BIT_RATE_STANDBY];
      tso_reg  <= pwr1_reg[BIT_THERMAL_SENSOR_OFF];
      src_reg  <= src_auto_pll ? SCF_SRC_AUTO :
                  (src_sel == SCF_SRC_STOP ? SCF_SRC_STOP : SCF_SRC_OSC);
      tgr_reg  <= (src_sel == SCF_SRC_STOP);
      lpe_reg  <= pwr2_reg[BIT_QUEUE_LOW_POWER_ENABLE];
      axis_reg <= pwr2_reg[5:0];
    end
  end

  assign reg_rdata               = rdata_reg;
  assign sensor_ready            = sens_ready;
  assign queue_enable            = qen_reg;
  assign two_wire_target_disable = twd_reg;
  assign signal_path_clear_all   = spc_reg;
  assign sleep_mode              = slp_reg;
  assign accel_cycle_active      = cyc_reg;
  assign cycle_take_sample       = smp_reg;
  assign rate_sense_off          = rso_reg;
  assign rate_drive_on           = rdo_reg;
  assign thermal_sensor_off      = tso_reg;
  assign timing_source           = src_reg;
  assign timing_gen_reset        = tgr_reg;
  assign queue_low_power_enable  = lpe_reg;
  assign axis_off                = axis_reg;
  assign queue_overflow_flag     = ovf_reg;
endmodule

// ---- sim/scf_regs_sva.sv ----
`timescale 1ns/100ps
module scf_regs_sva import scf_pkg::*; (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Stream and controls
  input wire logic       sensor_valid,
  input wire logic       queue_enable,
  input wire logic       signal_path_clear_all,
  input wire logic       sleep_mode,
  input wire logic       accel_cycle_active,
  input wire logic       cycle_take_sample,
  input wire logic       rate_sense_off,
  input wire logic       rate_drive_on,
  input wire logic [1:0] timing_source,
  input wire logic       timing_gen_reset,
  input wire logic [5:0] axis_off,
  input wire logic       queue_overflow_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_ident_read: assert property (reg_rd && reg_addr == OFS_IDENTITY |=>
    reg_rdata == PART_IDENTITY_CODE) else $error("identity read wrong");
  a_count_reserved: assert property (reg_rd && reg_addr == OFS_COUNT_HIGH |=>
    reg_rdata[7:5] == 3'h0) else $error("count high reserved bits set");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_port_blocked: assert property (reg_rd && reg_addr == OFS_DATA_PORT &&
    !queue_enable && !$past(reg_wr) |=> reg_rdata == EMPTY_READ_VALUE)
    else $error("blocked port read not 0xFF");
  a_reset_asleep: assert property ($fell(rst) |-> sleep_mode &&
    timing_source == 2'h0) else $error("wrong state after reset");
  a_stop_gen: assert property (timing_gen_reset == (timing_source == 2'h3))
    else $error("timing generator reset mismatch");
  a_cycle_gate: assert property (accel_cycle_active |-> !sleep_mode &&
    !rate_sense_off) else $error("cycling while asleep or in standby");
  a_sample_gate: assert property (cycle_take_sample |-> accel_cycle_active &&
    axis_off[5:3] != 3'h7) else $error("sample with all accel axes off");
  a_clear_cause: assert property (signal_path_clear_all |-> $past(reg_wr) &&
    $past(reg_addr) == OFS_USER_CONTROL && $past(reg_wdata[0]))
    else $error("path clear without write");
  a_drive_kept: assert property (rate_drive_on)
    else $error("rate drive off");
  a_ovf_cause: assert property (queue_overflow_flag |->
    $past(sensor_valid) || $past(reg_wr)) else $error("overflow without a push");
endmodule
bind scf_regs scf_regs_sva u_sva (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
  .reg_rdata, .sensor_valid, .queue_enable, .signal_path_clear_all, .sleep_mode,
  .accel_cycle_active, .cycle_take_sample, .rate_sense_off, .rate_drive_on,
  .timing_source, .timing_gen_reset, .axis_off, .queue_overflow_flag);

// ---- sim/scf_sensor_src.sv ----
`timescale 1ns/100ps
module scf_sensor_src (
  // Clock
  input  wire logic       clk,
  // Byte stream
  output logic            sensor_valid,
  output logic [7:0]      sensor_data,
  output logic            sensor_enabled,
  input  wire logic       sensor_ready
);
  initial begin
    sensor_valid   = 1'b0;
    sensor_data    = 8'h00;
    sensor_enabled = 1'b0;
  end
  // Offer one byte and hold it until taken or the wait runs out
  task automatic offer(input logic [7:0] d, input logic en, output logic tk);
    int n;
    n = 0;
    tk = 1'b0;
    @(posedge clk);
    #1;
    sensor_valid   = 1'b1;
    sensor_data    = (d == 8'hFF) ? 8'hFE : d;
    sensor_enabled = en;
    while (!tk && n < 40) begin
      @(posedge clk);
      tk = sensor_ready;
      n++;
    end
    #1;
    sensor_valid   = 1'b0;
    sensor_data    = ~sensor_data;
    sensor_enabled = ~en;
  endtask
endmodule

// ---- sim/tb_sensor_control_fifo_regs.sv ----
`timescale 1ns/100ps
module tb_sensor_control_fifo_regs import scf_pkg::*; ;
  localparam int QDEPTH = 32;
  logic        clk, rst, reg_wr, reg_rd, queue_mode_keep, pll_ready, sensor_valid;
  logic        sensor_enabled, sensor_ready, queue_enable, two_wire_target_disable;
  logic        signal_path_clear_all, sleep_mode, accel_cycle_active, cycle_take_sample;
  logic        rate_sense_off, rate_drive_on, thermal_sensor_off, timing_gen_reset;
  logic        queue_low_power_enable, queue_overflow_flag;
  logic [1:0]  timing_source;
  logic [5:0]  axis_off;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, sensor_data, v;
  logic [16:0] lfsr;
  int          error_cnt, num_checks, ovf_cnt, ovf_exp;
  int          q[$];
  scf_regs #(.DEPTH(QDEPTH)) uut (.clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .sensor_valid, .sensor_data, .sensor_enabled, .sensor_ready,
    .queue_mode_keep, .pll_ready, .queue_enable, .two_wire_target_disable,
    .signal_path_clear_all, .sleep_mode, .accel_cycle_active, .cycle_take_sample,
    .rate_sense_off, .rate_drive_on, .thermal_sensor_off, .timing_source,
    .timing_gen_reset, .queue_low_power_enable, .axis_off, .queue_overflow_flag);
  scf_sensor_src src (.clk, .sensor_valid, .sensor_data, .sensor_enabled, .sensor_ready);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) if (queue_overflow_flag === 1'b1) ovf_cnt++;
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[15:0], lfsr[16] ^ lfsr[13]};
    return (lfsr[7:0] == 8'hFF) ? 8'h00 : lfsr[7:0];
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr    = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rck(input logic [6:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk(nm, reg_rdata, e);
  endtask
  task automatic push(input logic [7:0] d, input logic en);
    logic tk, ex;
    ex = !(queue_mode_keep && en && q.size() == QDEPTH);
    src.offer(d, en, tk);
    chk("taken", tk, ex);
    if (tk && en) begin
      if (q.size() == QDEPTH) begin
        ovf_exp++;
        void'(q.pop_front());
      end
      q.push_back(d);
    end
  endtask
  task automatic cnt();
    rck(OFS_COUNT_HIGH, 8'(q.size() >> 8), "count_high");
    rck(OFS_COUNT_LOW, 8'(q.size()), "count_low");
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      rck(OFS_DATA_PORT, (q.size() > 0) ? 8'(q.pop_front()) : EMPTY_READ_VALUE, "port");
    end
  endtask
  task automatic end_of_test();
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #200000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata, queue_mode_keep, pll_ready} = 20'h80000;
    {lfsr, error_cnt, num_checks, ovf_cnt, ovf_exp} = {17'h181D0, 128'h0};
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("sleep", sleep_mode, 1'b1);
    chk("drive", rate_drive_on, 1'b1);
    rck(OFS_USER_CONTROL, RST_USER_CONTROL, "user");
    rck(OFS_POWER_ONE, RST_POWER_ONE, "pwr1");
    rck(OFS_POWER_TWO, RST_POWER_TWO, "pwr2");
    wr(OFS_IDENTITY, 8'h00);
    rck(OFS_IDENTITY, PART_IDENTITY_CODE, "ident");
    rck(7'h7F, 8'h00, "unmapped");
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      wr(OFS_POWER_TWO, v);
      rck(OFS_POWER_TWO, v & MASK_POWER_TWO, "pwr2");
      chk("axis", axis_off, v[5:0]);
      chk("lowpwr", queue_low_power_enable, v[7]);
      wr(OFS_POWER_ONE, v & 8'h7F);
      rck(OFS_POWER_ONE, v & MASK_POWER_ONE, "pwr1");
      chk("sleep", sleep_mode, v[6]);
      chk("standby", rate_sense_off, v[4]);
      chk("thermal", thermal_sensor_off, v[3]);
      chk("cycle", accel_cycle_active, v[5] & ~v[6] & ~v[4]);
      wr(OFS_USER_CONTROL, v & 8'h50);
      rck(OFS_USER_CONTROL, v & 8'h50, "user");
      chk("twowire", two_wire_target_disable, v[4]);
      chk("qen", queue_enable, v[6]);
    end
    for (int c = 0; c < 16; c++) begin
      pll_ready = c[3];
      wr(OFS_POWER_ONE, 8'(c[2:0]));
      rck(OFS_POWER_ONE, 8'(c[2:0]), "pwr1");
      chk("source", timing_source, (c[2:0] == 3'h7) ? 2'h3 :
        (c[2:0] == 3'h0 || c[2:0] == 3'h6 || !c[3]) ? 2'h0 : 2'h1);
      chk("genreset", timing_gen_reset, c[2:0] == 3'h7);
    end
    wr(OFS_POWER_TWO, 8'h38);
    wr(OFS_POWER_ONE, 8'h21);
    repeat (40) @(posedge clk);
    #1;
    chk("cycle", accel_cycle_active, 1'b1);
    chk("sample", cycle_take_sample, 1'b0);
    wr(OFS_POWER_TWO, 8'h00);
    rck(OFS_POWER_TWO, 8'h00, "pwr2");
    chk("sample", cycle_take_sample, 1'b1);
    wr(OFS_USER_CONTROL, 8'h41);
    chk("pathclr", signal_path_clear_all, 1'b1);
    rck(OFS_USER_CONTROL, 8'h40, "user");
    chk("pathclr", signal_path_clear_all, 1'b0);
    for (int i = 0; i < 40; i++) push(rnd(), i % 7 != 3);
    cnt();
    chk("overflow", 16'(ovf_cnt), 16'(ovf_exp));
    drain(10);
    wr(OFS_DATA_PORT, 8'h3C);
    q.push_back(8'h3C);
    cnt();
    drain(q.size() + 1);
    queue_mode_keep = 1'b1;
    for (int i = 0; i < QDEPTH + 1; i++) push(rnd(), 1'b1);
    cnt();
    drain(QDEPTH + 1);
    queue_mode_keep = 1'b0;
    for (int i = 0; i < 3; i++) push(rnd(), 1'b1);
    wr(OFS_USER_CONTROL, 8'h44);
    q.delete();
    repeat (8) @(posedge clk);
    cnt();
    rck(OFS_USER_CONTROL, 8'h40, "user");
    wr(OFS_USER_CONTROL, 8'h00);
    push(8'h11, 1'b1);
    rck(OFS_DATA_PORT, EMPTY_READ_VALUE, "blocked");
    wr(OFS_DATA_PORT, 8'h22);
    wr(OFS_USER_CONTROL, 8'h40);
    drain(2);
    push(8'h33, 1'b1);
    wr(OFS_POWER_ONE, 8'h80);
    q.delete();
    rck(OFS_USER_CONTROL, RST_USER_CONTROL, "user");
    rck(OFS_POWER_ONE, RST_POWER_ONE, "pwr1");
    cnt();
    end_of_test();
  end
endmodule
